//--- hdl/jbiup_pkg.sv
// Shared constants and types of the test access port block
package jbiup_pkg;

  localparam int          IR_W          = 8;
  localparam int          DR_W          = 32;
  localparam int          FIFO_DEPTH    = 8;
  localparam logic [2:0]  TLR_TMS_EDGES = 3'h5;

  // Instruction opcodes, bit 0 is the first bit shifted in
  localparam logic [7:0]  OP_BYPASS     = 8'hFF;
  localparam logic [7:0]  OP_IDCODE     = 8'h01;
  localparam logic [7:0]  OP_USERCODE   = 8'hDF;
  localparam logic [7:0]  OP_OTF_WRITE  = 8'h2A;
  localparam logic [7:0]  OP_SRAM_WRITE = 8'h3C;
  localparam logic [7:0]  OP_SRAM_READ  = 8'h3D;
  localparam logic [7:0]  OP_ACTIVATE   = 8'h0F;

  localparam logic [7:0]  IR_CAPTURE    = 8'h01;
  localparam logic [7:0]  IR_RESET      = OP_IDCODE;
  // Identification word: arbitrary neutral value
  localparam logic [31:0] ID_WORD_DEF   = 32'h0A5A5001;

  typedef enum logic [3:0] {
    TAP_RESET   = 4'h0,
    TAP_IDLE    = 4'h1,
    TAP_SEL_DR  = 4'h2,
    TAP_CAP_DR  = 4'h3,
    TAP_SH_DR   = 4'h4,
    TAP_EX1_DR  = 4'h5,
    TAP_PAU_DR  = 4'h6,
    TAP_EX2_DR  = 4'h7,
    TAP_UPD_DR  = 4'h8,
    TAP_SEL_IR  = 4'h9,
    TAP_CAP_IR  = 4'hA,
    TAP_SH_IR   = 4'hB,
    TAP_EX1_IR  = 4'hC,
    TAP_PAU_IR  = 4'hD,
    TAP_EX2_IR  = 4'hE,
    TAP_UPD_IR  = 4'hF
  } jbiup_tap_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jbiup_pins_t;

  typedef struct packed {
    logic        to_sram;
    logic [31:0] data;
  } jbiup_word_t;

endpackage : jbiup_pkg

//--- hdl/jbiup_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module jbiup_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,    // System clock
  input  wire logic         rst,    // Synchronous reset
  input  wire logic [W-1:0] d,      // Asynchronous inputs
  output logic      [W-1:0] q       // Synchronised outputs
);
  logic [W-1:0] meta_q;

  initial begin
    if (W < 1) $error("jbiup_sync: W must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : jbiup_sync

//--- hdl/jbiup_fifo.sv
// Small valid/ready FIFO for configuration words
`timescale 1ns/1ps
module jbiup_fifo #(
  parameter int W     = 33,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,        // System clock
  input  wire logic         rst,        // Synchronous reset
  input  wire logic         in_valid,   // Write request
  output logic              in_ready,   // Not full
  input  wire logic [W-1:0] in_data,    // Write data
  output logic              out_valid,  // Not empty
  input  wire logic         out_ready,  // Drain accepts
  output logic      [W-1:0] out_data    // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q, wr_d, rd_q, rd_d;
  logic         push, pop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("jbiup_fifo: DEPTH must be a power of two");
  end

  assign in_ready  = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop  ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule : jbiup_fifo

//--- hdl/jbiup_port.sv
// Test access port controller with bypass, identification and signature scans
`timescale 1ns/1ps
module jbiup_port #(
  parameter logic [31:0] ID_WORD = jbiup_pkg::ID_WORD_DEF
) (
  input  wire logic               clk,          // 125 MHz system clock
  input  wire logic               rst,          // Synchronous reset, active high
  input  wire logic               tck,          // Test clock pin
  input  wire logic               tms,          // Test mode select pin
  input  wire logic               tdi,          // Test data in pin
  output logic                    tdo_o,        // Test data out
  output logic                    tdo_oe_n,     // Low while TDO is driven
  input  wire logic [31:0]        usercode,     // Stored user signature
  input  wire logic [31:0]        sram_rdata,   // Pattern memory read-back word
  output logic                    wr_valid,     // Configuration word available
  input  wire logic               wr_ready,     // Memory side accepts word
  output jbiup_pkg::jbiup_word_t  wr_word,      // Word and its destination
  output logic                    fill_ready,   // Room for another word
  output logic                    cfg_activate, // Switch to stored configuration
  output logic [7:0]              ir_active,    // Active instruction
  output jbiup_pkg::jbiup_tap_t   tap_state     // Controller state
);
  jbiup_pkg::jbiup_pins_t pins_raw, pins_s;
  jbiup_pkg::jbiup_tap_t  st_q, st_d;
  jbiup_pkg::jbiup_word_t push_word;
  logic [7:0]             ir_q, ir_d, irsh_q, irsh_d;
  logic [31:0]            dr_q, dr_d;
  logic                   byp_q, byp_d, tdo_q, tdo_d, oen_q, oen_d;
  logic                   tck_q, act_q, act_d, push_q, push_d;
  logic                   rise, fall, is_write;

  assign pins_raw = '{tck: tck, tms: tms, tdi: tdi};

  jbiup_sync #(.W(3)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pins_raw),
    .q   (pins_s)
  );

  assign rise     = pins_s.tck && !tck_q;
  assign fall     = !pins_s.tck && tck_q;
  assign is_write = (ir_q == jbiup_pkg::OP_OTF_WRITE) || (ir_q == jbiup_pkg::OP_SRAM_WRITE);

  function automatic jbiup_pkg::jbiup_tap_t tap_next(jbiup_pkg::jbiup_tap_t s, logic m);
    unique case (s)
      jbiup_pkg::TAP_RESET:  tap_next = m ? jbiup_pkg::TAP_RESET  : jbiup_pkg::TAP_IDLE;
      jbiup_pkg::TAP_IDLE:   tap_next = m ? jbiup_pkg::TAP_SEL_DR : jbiup_pkg::TAP_IDLE;
      jbiup_pkg::TAP_SEL_DR: tap_next = m ? jbiup_pkg::TAP_SEL_IR : jbiup_pkg::TAP_CAP_DR;
      jbiup_pkg::TAP_CAP_DR: tap_next = m ? jbiup_pkg::TAP_EX1_DR : jbiup_pkg::TAP_SH_DR;
      jbiup_pkg::TAP_SH_DR:  tap_next = m ? jbiup_pkg::TAP_EX1_DR : jbiup_pkg::TAP_SH_DR;
      jbiup_pkg::TAP_EX1_DR: tap_next = m ? jbiup_pkg::TAP_UPD_DR : jbiup_pkg::TAP_PAU_DR;
      jbiup_pkg::TAP_PAU_DR: tap_next = m ? jbiup_pkg::TAP_EX2_DR : jbiup_pkg::TAP_PAU_DR;
      jbiup_pkg::TAP_EX2_DR: tap_next = m ? jbiup_pkg::TAP_UPD_DR : jbiup_pkg::TAP_SH_DR;
      jbiup_pkg::TAP_UPD_DR: tap_next = m ? jbiup_pkg::TAP_SEL_DR : jbiup_pkg::TAP_IDLE;
      jbiup_pkg::TAP_SEL_IR: tap_next = m ? jbiup_pkg::TAP_RESET  : jbiup_pkg::TAP_CAP_IR;
      jbiup_pkg::TAP_CAP_IR: tap_next = m ? jbiup_pkg::TAP_EX1_IR : jbiup_pkg::TAP_SH_IR;
      jbiup_pkg::TAP_SH_IR:  tap_next = m ? jbiup_pkg::TAP_EX1_IR : jbiup_pkg::TAP_SH_IR;
      jbiup_pkg::TAP_EX1_IR: tap_next = m ? jbiup_pkg::TAP_UPD_IR : jbiup_pkg::TAP_PAU_IR;
      jbiup_pkg::TAP_PAU_IR: tap_next = m ? jbiup_pkg::TAP_EX2_IR : jbiup_pkg::TAP_PAU_IR;
      jbiup_pkg::TAP_EX2_IR: tap_next = m ? jbiup_pkg::TAP_UPD_IR : jbiup_pkg::TAP_SH_IR;
      jbiup_pkg::TAP_UPD_IR: tap_next = m ? jbiup_pkg::TAP_SEL_DR : jbiup_pkg::TAP_IDLE;
    endcase
  endfunction : tap_next

  always_comb begin
    st_d   = st_q;
    ir_d   = ir_q;
    irsh_d = irsh_q;
    dr_d   = dr_q;
    byp_d  = byp_q;
    tdo_d  = tdo_q;
    oen_d  = oen_q;
    act_d  = 1'b0;
    push_d = 1'b0;
    if (rise) begin
      st_d = tap_next(st_q, pins_s.tms);
      unique case (st_q)
        jbiup_pkg::TAP_CAP_IR: irsh_d = jbiup_pkg::IR_CAPTURE;
        // Shifts also on the exit edge, so bit 7 lands with TMS high
        jbiup_pkg::TAP_SH_IR: irsh_d = {pins_s.tdi, irsh_q[7:1]};
        jbiup_pkg::TAP_CAP_DR: begin
          byp_d = 1'b0;
          unique case (ir_q)
            jbiup_pkg::OP_IDCODE:    dr_d = ID_WORD;
            jbiup_pkg::OP_USERCODE:  dr_d = usercode;
            jbiup_pkg::OP_SRAM_READ: dr_d = sram_rdata;
            default:                 dr_d = {31'h0, fill_ready};
          endcase
        end
        jbiup_pkg::TAP_SH_DR: begin
          dr_d  = {pins_s.tdi, dr_q[31:1]};
          byp_d = pins_s.tdi;
        end
        // Writes go to memory ports only; the live configuration is untouched
        jbiup_pkg::TAP_UPD_DR: push_d = is_write;
        default: ;
      endcase
      // Act on the edge that enters the state, so a short pass still takes effect
      if (st_d == jbiup_pkg::TAP_RESET) begin
        ir_d = jbiup_pkg::IR_RESET;
      end else if (st_d == jbiup_pkg::TAP_UPD_IR) begin
        ir_d  = irsh_q;
        act_d = (irsh_q == jbiup_pkg::OP_ACTIVATE);
      end
    end
    if (fall) begin
      // Only TDO changes, functional pins are never driven here
      oen_d = !(st_q == jbiup_pkg::TAP_SH_DR || st_q == jbiup_pkg::TAP_SH_IR);
      if (st_q == jbiup_pkg::TAP_SH_IR) begin
        tdo_d = irsh_q[0];
      end else if (ir_q == jbiup_pkg::OP_IDCODE || ir_q == jbiup_pkg::OP_USERCODE ||
                   ir_q == jbiup_pkg::OP_SRAM_READ || is_write) begin
        tdo_d = dr_q[0];
      end else begin
        tdo_d = byp_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q   <= jbiup_pkg::TAP_RESET;
      ir_q   <= jbiup_pkg::IR_RESET;
      irsh_q <= jbiup_pkg::IR_CAPTURE;
      dr_q   <= '0;
      byp_q  <= 1'b0;
      tdo_q  <= 1'b0;
      oen_q  <= 1'b1;
      tck_q  <= 1'b0;
      act_q  <= 1'b0;
      push_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      ir_q   <= ir_d;
      irsh_q <= irsh_d;
      dr_q   <= dr_d;
      byp_q  <= byp_d;
      tdo_q  <= tdo_d;
      oen_q  <= oen_d;
      tck_q  <= pins_s.tck;
      act_q  <= act_d;
      push_q <= push_d;
    end
  end

  // A word arriving while full is dropped; software polls the ready bit first
  assign push_word = '{to_sram: (ir_q == jbiup_pkg::OP_SRAM_WRITE), data: dr_q};

  jbiup_fifo #(.W(33), .DEPTH(jbiup_pkg::FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push_q),
    .in_ready  (fill_ready),
    .in_data   (push_word),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_word)
  );

  assign tdo_o        = tdo_q;
  assign tdo_oe_n     = oen_q;
  assign cfg_activate = act_q;
  assign ir_active    = ir_q;
  assign tap_state    = st_q;

  // Checking logic
  logic [2:0] hi_cnt_q, hi_cnt_d;

  always_comb begin
    hi_cnt_d = hi_cnt_q;
    if (rise) hi_cnt_d = !pins_s.tms ? 3'h0 : (hi_cnt_q == 3'h7 ? 3'h7 : hi_cnt_q + 3'h1);
  end

  always_ff @(posedge clk) begin
    if (rst) hi_cnt_q <= 3'h0;
    else     hi_cnt_q <= hi_cnt_d;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence rise_in_s(jbiup_pkg::jbiup_tap_t s);
    rise && st_q == s;
  endsequence

  sequence fall_in_sh_dr_s;
    fall && st_q == jbiup_pkg::TAP_SH_DR;
  endsequence

  tms_reset_a: assert property (hi_cnt_q >= jbiup_pkg::TLR_TMS_EDGES |-> st_q == jbiup_pkg::TAP_RESET)
    else $error("five high TMS edges did not reach reset");
  ir_update_a: assert property (ir_q != $past(ir_q) |-> $past(rise) &&
                                (st_q == jbiup_pkg::TAP_UPD_IR || st_q == jbiup_pkg::TAP_RESET))
    else $error("instruction changed outside update");
  bypass_load_a: assert property (rise_in_s(jbiup_pkg::TAP_EX1_IR) ##0 pins_s.tms && irsh_q == 8'hFF
                                  |=> ir_q == jbiup_pkg::OP_BYPASS)
    else $error("all ones did not select bypass");
  bypass_delay_a: assert property (fall_in_sh_dr_s ##0 ir_q == jbiup_pkg::OP_BYPASS
                                   |=> tdo_q == $past(byp_q) && !tdo_oe_n)
    else $error("bypass bit not on TDO at fall");
  id_shift_a: assert property (fall_in_sh_dr_s ##0 ir_q == jbiup_pkg::OP_IDCODE |=> tdo_q == $past(dr_q[0]))
    else $error("identification bit not on TDO at fall");
  sram_capture_a: assert property (rise_in_s(jbiup_pkg::TAP_CAP_DR) ##0 ir_q == jbiup_pkg::OP_SRAM_READ
                                   |=> dr_q == $past(sram_rdata))
    else $error("pattern word not captured");
  ir_hold_a: assert property (rise_in_s(jbiup_pkg::TAP_SH_IR) |=> ir_q == $past(ir_q))
    else $error("instruction changed while shifting");
  tdo_quiet_a: assert property (!fall |=> tdo_q == $past(tdo_q))
    else $error("TDO changed away from a TCK fall");
  word_push_a: assert property (push_q && fill_ready |=> wr_valid)
    else $error("pushed word not offered");
  id_capture_a: assert property (rise_in_s(jbiup_pkg::TAP_CAP_DR) ##0 ir_q == jbiup_pkg::OP_IDCODE |=> dr_q == ID_WORD)
    else $error("identification word not captured");
  user_capture_a: assert property (rise_in_s(jbiup_pkg::TAP_CAP_DR) ##0 ir_q == jbiup_pkg::OP_USERCODE
                                   |=> dr_q == $past(usercode))
    else $error("signature not captured");
  ir_exit_a: assert property (rise_in_s(jbiup_pkg::TAP_SH_IR) ##0 pins_s.tms |=> st_q == jbiup_pkg::TAP_EX1_IR &&
                              irsh_q[7] == $past(pins_s.tdi))
    else $error("bit 7 not shifted on exit edge");
  dr_exit_a: assert property (rise_in_s(jbiup_pkg::TAP_SH_DR) ##0 pins_s.tms |=> st_q == jbiup_pkg::TAP_EX1_DR &&
                              dr_q[31] == $past(pins_s.tdi))
    else $error("last data bit not shifted on exit");
  activate_only_a: assert property (cfg_activate |-> ir_q == jbiup_pkg::OP_ACTIVATE ##1 !cfg_activate)
    else $error("activation without explicit command");
  tdo_drive_a: assert property (!tdo_oe_n |-> st_q == jbiup_pkg::TAP_SH_DR || st_q == jbiup_pkg::TAP_SH_IR ||
                                $past(st_q) inside {jbiup_pkg::TAP_SH_DR, jbiup_pkg::TAP_SH_IR} ||
                                st_q inside {jbiup_pkg::TAP_EX1_DR, jbiup_pkg::TAP_EX1_IR})
    else $error("TDO driven outside shift");
  push_write_a: assert property (push_q |-> is_write && $past(st_q) == jbiup_pkg::TAP_UPD_DR)
    else $error("word pushed outside write update");
endmodule : jbiup_port

//--- bench/jbiup_prog.sv
// Programmer model that walks the test port from the far side
`timescale 1ns/1ps
module jbiup_prog (
  input  wire logic clk,      // Pacing clock
  output logic      tck,      // Test clock, low outside frames
  output logic      tms,      // Mode select
  output logic      tdi,      // Data into the device
  input  wire logic tdo,      // Data from the device
  input  wire logic tdo_oe_n  // Low while the device drives tdo
);
  localparam int HALF = 10;   // 80 ns phases at 8 ns
  logic seen_oe_n;

  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    seen_oe_n = 1'b1;
  end

  // Sample tdo just before the rise, long after the falling-edge update
  task automatic tick(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (HALF) @(posedge clk);
    q = tdo;
    seen_oe_n = tdo_oe_n;
    tck <= 1'b1;
    repeat (HALF) @(posedge clk);
    tck <= 1'b0;
  endtask : tick

  // Don't-care data toggles so a stale level never passes for real data
  task automatic walk(input logic m);
    logic q;
    tick(m, ~tdi, q);
  endtask : walk

  task automatic to_reset();
    repeat (5) walk(1'b1);
  endtask : to_reset

  // Ends in Exit1-IR so the caller can look before Update-IR
  task automatic load_ir(input logic [7:0] op);
    logic q;
    to_reset();
    walk(1'b0);
    walk(1'b1);
    walk(1'b1);
    walk(1'b0);
    walk(1'b0);
    for (int i = 0; i < 7; i++) tick(1'b0, op[i], q);
    tick(1'b1, op[7], q);
  endtask : load_ir

  // Starts in Update-IR, returns in Test-Logic/Reset
  task automatic dr_scan(input logic [31:0] din, output logic [31:0] dout, output logic oe_hi);
    oe_hi = 1'b0;
    walk(1'b1);
    walk(1'b0);
    walk(1'b0);
    for (int i = 0; i < 32; i++) begin
      tick(i == 31, din[i], dout[i]);
      oe_hi = oe_hi | seen_oe_n;
    end
    repeat (4) walk(1'b1);
  endtask : dr_scan
endmodule : jbiup_prog

//--- bench/jbiup_port_tb.sv
// Self-checking bench for the test access port block
`timescale 1ns/1ps
module jtag_bypass_id_usercode_port_tb;
  logic                   clk, rst, tck, tms, tdi, tdo_o, tdo_oe_n, oe_hi;
  logic                   wr_valid, wr_ready, fill_ready, cfg_activate;
  logic [7:0]             ir_active, op;
  logic [7:0]             ops[3];
  logic [31:0]            usercode, sram_rdata, rnd_q, din, dout;
  logic [32:0]            sent_q[$];
  jbiup_pkg::jbiup_word_t wr_word;
  jbiup_pkg::jbiup_tap_t  tap_state;
  int                     miscompares = 0;
  int                     checked = 0;
  int                     pulses = 0;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  jbiup_port dut_u (
    .clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
    .tdo_oe_n(tdo_oe_n), .usercode(usercode), .sram_rdata(sram_rdata),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word), .fill_ready(fill_ready),
    .cfg_activate(cfg_activate), .ir_active(ir_active), .tap_state(tap_state)
  );

  jbiup_prog prog_u (
    .clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_o), .tdo_oe_n(tdo_oe_n)
  );

  // Counting high cycles also catches a pulse that lasts too long
  always @(posedge clk) if (cfg_activate === 1'b1) pulses <= pulses + 1;

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  function automatic logic [32:0] word_exp(input logic [7:0] o, input logic [31:0] d);
    return {o == jbiup_pkg::OP_SRAM_WRITE, d};
  endfunction : word_exp

  // One stage of delay; the captured first bit is masked off
  function automatic logic [31:0] bypass_exp(input logic [31:0] d);
    return {d[30:0], 1'b0};
  endfunction : bypass_exp

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask : chk

  task automatic chk_flag(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: flag expected %h got %h", $time, exp, got);
    end
  endtask : chk_flag

  task automatic close_out();
    $display("Counts: checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  task automatic do_scan(input logic [7:0] o);
    rnd_q = xs(rnd_q);
    din = rnd_q;
    prog_u.load_ir(o);
    chk({25'h0, ir_active}, {25'h0, jbiup_pkg::IR_RESET});
    prog_u.walk(1'b1);
    chk({25'h0, ir_active}, {25'h0, o});
    prog_u.dr_scan(din, dout, oe_hi);
    chk_flag(oe_hi, 1'b0);
    chk({29'h0, tap_state}, {29'h0, jbiup_pkg::TAP_RESET});
  endtask : do_scan

  initial begin
    rst = 1'b1;
    wr_ready = 1'b0;
    usercode = 32'h0;
    sram_rdata = 32'h0;
    rnd_q = 32'h0000003E;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk_flag(tdo_oe_n, 1'b1);
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 3 + 2 * k; j++) begin
        rnd_q = xs(rnd_q);
        prog_u.walk(rnd_q[0]);
      end
      prog_u.to_reset();
      chk({29'h0, tap_state}, {29'h0, jbiup_pkg::TAP_RESET});
      chk({25'h0, ir_active}, {25'h0, jbiup_pkg::IR_RESET});
    end
    ops = '{jbiup_pkg::OP_BYPASS, jbiup_pkg::OP_IDCODE, jbiup_pkg::OP_USERCODE};
    foreach (ops[i]) begin
      rnd_q = xs(rnd_q);
      usercode <= rnd_q;
      do_scan(ops[i]);
      if (ops[i] == jbiup_pkg::OP_BYPASS)
        chk({1'b0, dout[31:1], 1'b0}, {1'b0, bypass_exp(din)});
      else if (ops[i] == jbiup_pkg::OP_IDCODE)
        chk({1'b0, dout}, {1'b0, jbiup_pkg::ID_WORD_DEF});
      else
        chk({1'b0, dout}, {1'b0, usercode});
      chk_flag(wr_valid, 1'b0);
      chk(33'(pulses), 33'h0);
    end
    // Memory side stalls while nine words are offered to an 8-deep buffer
    for (int k = 0; k < 9; k++) begin
      op = k[0] ? jbiup_pkg::OP_SRAM_WRITE : jbiup_pkg::OP_OTF_WRITE;
      do_scan(op);
      chk({1'b0, dout}, {32'h0, k < 8});
      if (k < 8) sent_q.push_back(word_exp(op, din));
    end
    chk_flag(fill_ready, 1'b0);
    chk(33'(pulses), 33'h0);
    for (int c = 0; c < 400 && sent_q.size() > 0; c++) begin
      @(posedge clk);
      if (wr_valid === 1'b1 && wr_ready === 1'b1) chk(wr_word, sent_q.pop_front());
      rnd_q = xs(rnd_q);
      wr_ready <= rnd_q[0];
    end
    if (sent_q.size() != 0) begin
      miscompares++;
      $display("Error at %0t: expected %h got %h", $time, 0, sent_q.size());
      close_out();
    end
    wr_ready <= 1'b0;
    repeat (2) @(posedge clk);
    chk_flag(wr_valid, 1'b0);
    chk_flag(fill_ready, 1'b1);
    rnd_q = xs(rnd_q);
    sram_rdata <= rnd_q;
    do_scan(jbiup_pkg::OP_SRAM_READ);
    chk({1'b0, dout}, {1'b0, sram_rdata});
    do_scan(jbiup_pkg::OP_ACTIVATE);
    chk(33'(pulses), 33'h1);
    close_out();
  end
endmodule : jtag_bypass_id_usercode_port_tb
